// file: design/lds_chan.sv
// Purpose: one LED channel: current reached latches, recharge and charge keeping
// Assumes: all inputs already on clk_i
// Notes: recharge_o pulses once per recharge period while the condition holds
`timescale 1ns/1ps
`default_nettype none
module lds_chan #(
   parameter int MEAS_CYC = lds_pkg::LED_MEAS_CYC,
   parameter int RECH_CYC = lds_pkg::RECHARGE_CYC
) (
   input wire logic clk_i, // core clock
   input wire logic rst_b_i, // async reset, active low
   input wire logic pwm_i, // synchronised pwm level
   input wire logic reached_i, // target current reached, live
   input wire logic headroom_i, // low headroom on this channel
   input wire logic bs_uv_i, // bootstrap undervoltage
   input wire logic sw_toggling_i, // external switch toggles periodically
   input wire logic uv_i, // input supply below threshold
   input wire logic sample_i, // sample request pulse
   input wire logic drv_en_i, // gate driver enabled
   output logic latched_o, // latched current reached
   output logic live_o, // live current reached
   output logic recharge_o, // bootstrap recharge pulse
   output logic comp_en_o // charge compensation enable
);
   logic pwm_d_r;
   logic live_r;
   logic latched_r;
   logic recharge_r;
   logic comp_r;
   logic [15:0] low_cnt_r;
   logic [15:0] per_cnt_r;
   wire fall = pwm_d_r & ~pwm_i;
   wire low_long = (low_cnt_r == 16'(MEAS_CYC));
   wire per_end = (per_cnt_r == 16'(RECH_CYC - 1));
   wire want = ~sw_toggling_i & drv_en_i & (pwm_i ? ~live_r : low_long);
   wire live_nxt = (reached_i & pwm_i) | (live_r & ~(fall | uv_i | sample_i));
   wire latched_nxt = (uv_i | headroom_i) ? 1'b0 :
      ((fall | sample_i) ? live_r : latched_r);
   wire [15:0] low_cnt_nxt = pwm_i ? 16'h0000 : (low_long ? low_cnt_r : low_cnt_r + 16'h0001);
   wire [15:0] per_cnt_nxt = (~want | per_end) ? 16'h0000 : per_cnt_r + 16'h0001;
   wire comp_nxt = drv_en_i & ~pwm_i & ~bs_uv_i & ~headroom_i;

   // a period below three cycles cannot keep two idle cycles between pulses
   if (MEAS_CYC < 1 || MEAS_CYC > 65535 || RECH_CYC < 3 || RECH_CYC > 65535) begin : g_chk_time
      $error("lds_chan: timing count out of range");
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pwm_d_r <= 1'b0;
         live_r <= 1'b0;
         latched_r <= 1'b0;
         low_cnt_r <= 16'h0000;
         per_cnt_r <= 16'h0000;
         recharge_r <= 1'b0;
         comp_r <= 1'b0;
      end else begin
         pwm_d_r <= pwm_i;
         live_r <= live_nxt;
         latched_r <= latched_nxt;
         low_cnt_r <= low_cnt_nxt;
         per_cnt_r <= per_cnt_nxt;
         recharge_r <= want & per_end;
         comp_r <= comp_nxt;
      end
   end

   assign latched_o = latched_r;
   assign live_o = live_r;
   assign recharge_o = recharge_r;
   assign comp_en_o = comp_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   latch_on_fall_a: assert property (fall && !uv_i && !headroom_i |=> latched_r == $past(live_r))
      else $error("latched bit not copied on pwm fall");
   latch_clear_a: assert property (uv_i || headroom_i |=> !latched_r)
      else $error("latched bit not cleared");
   comp_gate_a: assert property (comp_r |-> $past(drv_en_i && !pwm_i && !bs_uv_i && !headroom_i))
      else $error("charge compensation enabled wrongly");
   recharge_space_a: assert property (recharge_r |=> !recharge_r [*2])
      else $error("recharge pulses too close");
   sample_live_a: assert property (sample_i && !(reached_i && pwm_i) |=> !live_r)
      else $error("live bit not cleared by sample");
   cov_recharge_c: cover property (recharge_r);
   cov_fall_c: cover property (fall && live_r);
endmodule
`default_nettype wire

// file: design/lds_pkg.sv
// Purpose: shared constants of the LED driver diagnostic status block
// Assumes: 20 MHz core clock, 16-bit serial frames
// Notes: times are given in ns and turned into cycle counts here
package lds_pkg;
   localparam int CLK_NS = 50;
   // serial frame layout: write flag, 7-bit address, 8-bit data
   localparam int FRAME_BITS = 16;
   localparam int WR_BIT = 15;
   localparam int ADDR_HI = 14;
   localparam int ADDR_LO = 8;
   // register offsets
   localparam logic [6:0] ADDR_FUNC_CTRL = 7'h00;
   localparam logic [6:0] ADDR_SAMPLE_REQ = 7'h06;
   localparam logic [6:0] ADDR_REACHED_LIVE = 7'h35;
   localparam logic [6:0] ADDR_PWM_TOGGLE = 7'h36;
   localparam logic [6:0] ADDR_OP_STATUS = 7'h37;
   // operating status field positions
   localparam int ST_SUPPLY_GOOD = 7;
   localparam int ST_LINK_ERR = 6;
   localparam int ST_OVERTEMP = 5;
   localparam int ST_GS_FAULT = 4;
   localparam int ST_GS_GOOD = 3;
   // function control and reached live field positions
   localparam int FC_LINK_READY = 7;
   localparam int FC_CLR_REQ = 6;
   localparam int FC_PWMCTRL_LO = 1;
   localparam int LIVE_LO = 3;
   // values after reset
   localparam logic [2:0] PWMCTRL_RST = 3'h7;
   localparam logic [7:0] REPLY_RST = 8'h00;
   // timing
   localparam int LED_MEAS_NS = 20000;
   localparam int RECHARGE_NS = 100000;
   localparam int GS_STARTUP_NS = 1000000;
   localparam int GS_OPER_NS = 100000;
   localparam int LED_MEAS_CYC = (LED_MEAS_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECHARGE_CYC = RECHARGE_NS / CLK_NS;
   localparam int GS_STARTUP_CYC = (GS_STARTUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int GS_OPER_CYC = (GS_OPER_NS + CLK_NS - 1) / CLK_NS;
endpackage

// file: design/lds_top.sv
// Purpose: operating status, sample request and channel diagnostics with serial access
// Assumes: host frames are 16 bits, sampled on rising sck, reply read on falling sck
// Notes: the reply to a frame appears in the following frame
`timescale 1ns/1ps
`default_nettype none
module lds_top #(
   parameter int NCH = 3,
   parameter int GS_STARTUP_CYC = lds_pkg::GS_STARTUP_CYC,
   parameter int GS_OPER_CYC = lds_pkg::GS_OPER_CYC,
   parameter int MEAS_CYC = lds_pkg::LED_MEAS_CYC,
   parameter int RECH_CYC = lds_pkg::RECHARGE_CYC
) (
   input wire logic clk_i, // core clock, 20 MHz
   input wire logic rst_b_i, // async reset, active low
   input wire logic spi_sck_i, // serial clock from host
   input wire logic spi_cs_b_i, // serial select, active low
   input wire logic spi_mosi_i, // serial data in
   output logic spi_miso_o, // serial data out
   output logic spi_miso_oe_o, // serial data out enable
   input wire logic en_i, // device enable pin, low is off mode
   input wire logic supply_ok_i, // input supply above threshold
   input wire logic overtemp_i, // junction over temperature
   input wire logic gsup_reg_ok_i, // gate supply at target
   input wire logic [NCH-1:0] pwm_i, // pwm pins
   input wire logic [NCH-1:0] reached_i, // target current reached
   input wire logic [NCH-1:0] headroom_i, // low headroom event
   input wire logic [NCH-1:0] bs_uv_i, // bootstrap undervoltage
   input wire logic [NCH-1:0] sw_toggling_i, // switch node toggles
   input wire logic [NCH-1:0] pwm_toggle_i, // pwm toggle bits, core clock
   output logic gate_drv_en_o, // gate driver and regulator enable
   output logic vled_update_o, // led voltage measurement may update
   output logic [NCH-1:0] chan_drive_o, // output current on per channel
   output logic [NCH-1:0] recharge_o, // bootstrap recharge pulse
   output logic [NCH-1:0] comp_en_o, // charge compensation enable
   output logic [7:0] op_status_o // operating status register
);
   localparam int SW = 5 * NCH + 5;
   localparam int GS_MAX = (GS_STARTUP_CYC > GS_OPER_CYC) ? GS_STARTUP_CYC : GS_OPER_CYC;
   localparam int GW = $clog2(GS_MAX + 1);

   if (NCH != 3) begin : g_chk_nch
      $error("lds_top: register layout serves exactly three channels");
   end
   if (GS_OPER_CYC < 1 || GS_STARTUP_CYC < 1) begin : g_chk_gs
      $error("lds_top: gate supply timeout must be at least one cycle");
   end

   // ---------------- link clock domain ----------------
   logic started_r;
   logic miso_r;
   logic miso_oe_r;
   logic full_r;
   logic [3:0] cnt_r;
   logic [15:0] rx_r;
   logic [15:0] tx_word_r;
   wire link_rst = ~rst_b_i | spi_cs_b_i;
   wire [3:0] tx_idx = started_r ? cnt_r : 4'h0;

   always_ff @(posedge spi_sck_i or posedge link_rst) begin
      if (link_rst) begin
         started_r <= 1'b0;
         miso_r <= 1'b0;
         miso_oe_r <= 1'b0;
      end else begin
         started_r <= 1'b1;
         miso_r <= tx_word_r[4'hF - tx_idx];
         miso_oe_r <= 1'b1;
      end
   end

   always_ff @(posedge spi_sck_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= 4'h0;
         full_r <= 1'b0;
         rx_r <= 16'h0000;
      end else begin
         cnt_r <= started_r ? cnt_r + 4'h1 : 4'h1;
         full_r <= started_r & (full_r | (cnt_r == 4'hF));
         rx_r <= {rx_r[14:0], spi_mosi_i};
      end
   end

   assign spi_miso_o = miso_r;
   assign spi_miso_oe_o = miso_oe_r;

   // ---------------- core clock domain: pin synchronisers ----------------
   logic [SW-1:0] sync1_r;
   logic [SW-1:0] sync2_r;
   logic cs_d_r;
   wire [SW-1:0] pins = {spi_cs_b_i, en_i, supply_ok_i, overtemp_i, gsup_reg_ok_i,
                         sw_toggling_i, bs_uv_i, headroom_i, reached_i, pwm_i};

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // pins read as idle low after reset, frame select as idle high
         sync1_r <= {1'b1, {(SW-1){1'b0}}};
         sync2_r <= {1'b1, {(SW-1){1'b0}}};
         cs_d_r <= 1'b1;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
         cs_d_r <= sync2_r[SW-1];
      end
   end

   wire [NCH-1:0] pwm_s = sync2_r[NCH-1:0];
   wire [NCH-1:0] reached_s = sync2_r[2*NCH-1:NCH];
   wire [NCH-1:0] headroom_s = sync2_r[3*NCH-1:2*NCH];
   wire [NCH-1:0] bs_uv_s = sync2_r[4*NCH-1:3*NCH];
   wire [NCH-1:0] sw_tog_s = sync2_r[5*NCH-1:4*NCH];
   wire gs_reg_ok_s = sync2_r[SW-5];
   wire overtemp_s = sync2_r[SW-4];
   wire supply_ok_s = sync2_r[SW-3];
   wire en_s = sync2_r[SW-2];
   wire cs_s = sync2_r[SW-1];
   wire frame_end = cs_s & ~cs_d_r;

   // ---------------- frame decode ----------------
   wire fr_wr = rx_r[lds_pkg::WR_BIT];
   wire [6:0] fr_addr = rx_r[lds_pkg::ADDR_HI:lds_pkg::ADDR_LO];
   wire [7:0] fr_dat = rx_r[7:0];
   wire fr_len_ok = full_r & (cnt_r == 4'h0);
   wire hit_func = (fr_addr == lds_pkg::ADDR_FUNC_CTRL);
   wire hit_sreq = (fr_addr == lds_pkg::ADDR_SAMPLE_REQ);
   wire hit_live = (fr_addr == lds_pkg::ADDR_REACHED_LIVE);
   wire hit_tog = (fr_addr == lds_pkg::ADDR_PWM_TOGGLE);
   wire hit_stat = (fr_addr == lds_pkg::ADDR_OP_STATUS);
   wire hit_any = hit_func | hit_sreq | hit_live | hit_tog | hit_stat;
   wire link_err_ev = frame_end & (~fr_len_ok | ~hit_any | (fr_wr & hit_live));
   wire wr_ok = frame_end & fr_wr & ~link_err_ev;

   // ---------------- status and control registers ----------------
   logic supply_good_flag_r;
   logic link_err_r;
   logic overtemp_flag_r;
   logic gate_supply_fault_r;
   logic gate_supply_good_r;
   logic clr_req_r;
   logic gs_was_good_r;
   logic drv_en_r;
   logic vled_upd_r;
   logic [GW-1:0] gs_cnt_r;
   logic [NCH-1:0] pwmctrl_r;
   logic [NCH-1:0] sample_req_r;
   logic [NCH-1:0] drive_r;
   logic [7:0] reply_r;
   wire [NCH-1:0] latched;
   wire [NCH-1:0] live;

   // fault clear acts only while a flag is up; the request waits otherwise
   wire do_clear = clr_req_r & (overtemp_flag_r | gate_supply_fault_r);
   wire ot_set = overtemp_s;
   wire [GW-1:0] gs_limit = gs_was_good_r ? GW'(GS_OPER_CYC) : GW'(GS_STARTUP_CYC);
   wire gs_timeout = drv_en_r & ~gs_reg_ok_s & (gs_cnt_r == gs_limit - GW'(1));
   wire fault_set = gs_timeout | (ot_set & gate_supply_good_r);
   wire [GW-1:0] gs_cnt_nxt = (drv_en_r & ~gs_reg_ok_s & ~gs_timeout) ? gs_cnt_r + GW'(1) : '0;
   wire ot_nxt = ot_set | (overtemp_flag_r & ~do_clear);
   wire fault_nxt = en_s & (fault_set | (gate_supply_fault_r & ~do_clear));
   wire drv_en_nxt = supply_ok_s & ~fault_nxt & ~ot_nxt;
   wire gsg_nxt = drv_en_r & gs_reg_ok_s & drv_en_nxt;
   wire clr_req_nxt = (wr_ok & hit_func & fr_dat[lds_pkg::FC_CLR_REQ]) |
      (clr_req_r & ~(do_clear & ~ot_set & ~fault_set));
   wire link_err_nxt = link_err_ev | (link_err_r & ~(wr_ok & hit_stat));
   wire [NCH-1:0] sreq_nxt = (wr_ok & hit_sreq) ? fr_dat[NCH-1:0] : {NCH{1'b0}};
   wire [NCH-1:0] pwmctrl_nxt = (wr_ok & hit_func) ? fr_dat[lds_pkg::FC_PWMCTRL_LO +: NCH] : pwmctrl_r;
   wire [7:0] op_status = {supply_good_flag_r, link_err_r, overtemp_flag_r, gate_supply_fault_r,
                           gate_supply_good_r, latched};

   // ---------------- read reply, returned in the next frame ----------------
   wire [7:0] rd_func = {1'b1, clr_req_r, 2'b00, pwmctrl_r, 1'b0};
   wire [7:0] rd_sreq = {5'h00, sample_req_r};
   wire [7:0] rd_live = {2'b00, live, 3'b000};
   wire [7:0] rd_tog = {5'h00, pwm_toggle_i};
   wire [7:0] rd_mux = hit_func ? rd_func :
                       hit_sreq ? rd_sreq :
                       hit_live ? rd_live :
                       hit_tog ? rd_tog :
                       hit_stat ? op_status : 8'h00;
   wire [7:0] reply_nxt = frame_end ? (link_err_ev ? rd_tog : rd_mux) : reply_r;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         supply_good_flag_r <= 1'b0;
         link_err_r <= 1'b0;
         overtemp_flag_r <= 1'b0;
         gate_supply_fault_r <= 1'b0;
         gate_supply_good_r <= 1'b0;
         clr_req_r <= 1'b0;
         gs_was_good_r <= 1'b0;
         gs_cnt_r <= '0;
         drv_en_r <= 1'b0;
      end else begin
         supply_good_flag_r <= supply_ok_s;
         link_err_r <= link_err_nxt;
         overtemp_flag_r <= ot_nxt;
         gate_supply_fault_r <= fault_nxt;
         gate_supply_good_r <= gsg_nxt;
         clr_req_r <= clr_req_nxt;
         gs_was_good_r <= drv_en_r & (gs_was_good_r | gs_reg_ok_s);
         gs_cnt_r <= gs_cnt_nxt;
         drv_en_r <= drv_en_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pwmctrl_r <= lds_pkg::PWMCTRL_RST;
         sample_req_r <= {NCH{1'b0}};
         drive_r <= {NCH{1'b0}};
         vled_upd_r <= 1'b0;
         reply_r <= lds_pkg::REPLY_RST;
         tx_word_r <= 16'h0000;
      end else begin
         pwmctrl_r <= pwmctrl_nxt;
         sample_req_r <= sreq_nxt;
         drive_r <= {NCH{drv_en_r}} & pwm_s & pwmctrl_r;
         vled_upd_r <= supply_good_flag_r & gate_supply_good_r;
         reply_r <= reply_nxt;
         tx_word_r <= cs_s ? {op_status, reply_r} : tx_word_r;
      end
   end

   // ---------------- channels ----------------
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      lds_chan #(
         .MEAS_CYC(MEAS_CYC),
         .RECH_CYC(RECH_CYC)
      ) u_chan (
         .clk_i(clk_i),
         .rst_b_i(rst_b_i),
         .pwm_i(pwm_s[i]),
         .reached_i(reached_s[i]),
         .headroom_i(headroom_s[i]),
         .bs_uv_i(bs_uv_s[i]),
         .sw_toggling_i(sw_tog_s[i]),
         .uv_i(~supply_good_flag_r),
         .sample_i(sample_req_r[i]),
         .drv_en_i(drv_en_r),
         .latched_o(latched[i]),
         .live_o(live[i]),
         .recharge_o(recharge_o[i]),
         .comp_en_o(comp_en_o[i])
      );
   end

   assign gate_drv_en_o = drv_en_r;
   assign vled_update_o = vled_upd_r;
   assign chan_drive_o = drive_r;
   assign op_status_o = {supply_good_flag_r, link_err_r, overtemp_flag_r, gate_supply_fault_r,
                         gate_supply_good_r, latched};

   // ---------------- checks ----------------
   supply_follow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      supply_ok_s |=> supply_good_flag_r)
      else $error("supply good flag not following input");
   supply_low_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !supply_good_flag_r |-> !drv_en_r && !gate_supply_good_r)
      else $error("driver or gate good active with supply low");
   link_err_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      link_err_ev |=> link_err_r)
      else $error("link error not flagged");
   bad_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      link_err_ev |=> $stable(pwmctrl_r) && sample_req_r == '0)
      else $error("erroneous write changed a register");
   link_err_clr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_ok && hit_stat |=> !link_err_r)
      else $error("link error not cleared by status write");
   err_reply_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      link_err_ev |=> reply_r == {5'h00, $past(pwm_toggle_i)})
      else $error("reply after error is not the toggle bits");
   overtemp_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      overtemp_s && gate_supply_good_r && en_s |=>
      overtemp_flag_r && gate_supply_fault_r && !gate_supply_good_r && !drv_en_r)
      else $error("overtemperature not handled");
   fault_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      do_clear && !ot_set && !fault_set && en_s |=> !overtemp_flag_r && !gate_supply_fault_r ##1 !clr_req_r)
      else $error("fault clear request not honoured");
   gs_timeout_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      gs_timeout && en_s |=> gate_supply_fault_r && !gate_supply_good_r && !drv_en_r)
      else $error("gate supply timeout not flagged");
   off_mode_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !en_s |=> !gate_supply_fault_r)
      else $error("fault survives off mode");
   sample_clr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_ok && hit_sreq |=> sample_req_r == $past(fr_dat[NCH-1:0]) ##1 sample_req_r == '0)
      else $error("sample request not self clearing");
   drive_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !drv_en_r |=> drive_r == '0)
      else $error("channel driven with driver off");
   vled_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !gate_supply_good_r |=> !vled_upd_r)
      else $error("measurement updated without gate supply good");
   drive_on_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      drv_en_r && pwm_s[0] && pwmctrl_r[0] |=> drive_r[0])
      else $error("channel not driven by pwm");
   good_needs_drv_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      gate_supply_good_r |-> drv_en_r)
      else $error("gate supply good with driver off");
   clr_req_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_ok && hit_func && fr_dat[lds_pkg::FC_CLR_REQ] |=> clr_req_r)
      else $error("clear request not taken");
   clr_wait_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      clr_req_r && !overtemp_flag_r && !gate_supply_fault_r |=> clr_req_r)
      else $error("clear request dropped with no error");
   err_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      link_err_r && !(wr_ok && hit_stat) |=> link_err_r)
      else $error("link error dropped without status write");
   ot_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      overtemp_flag_r && !do_clear |=> overtemp_flag_r)
      else $error("overtemperature flag dropped without clear");
   ot_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      overtemp_s |=> overtemp_flag_r)
      else $error("overtemperature flag not set");
   fault_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      gate_supply_fault_r && en_s && !do_clear |=> gate_supply_fault_r)
      else $error("gate supply fault dropped without clear");
   cov_err_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) link_err_ev ##[1:200] wr_ok && hit_stat);
   cov_ot_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) overtemp_flag_r ##[1:50] do_clear);
   cov_good_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(gate_supply_good_r));
endmodule
`default_nettype wire

// file: verification/lds_host_model.sv
// Purpose: serial host model that frames requests into the status block
// Assumes: mosi taken on rising sck, miso read on falling sck, 12 ns sck period
// Notes: sck stands low between frames; mosi parks on the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module lds_host_model (
   output logic sck_o, // serial clock
   output logic cs_b_o, // frame select, active low
   output logic mosi_o, // serial data to device
   input wire logic miso_i // serial data from device
);
   initial begin
      sck_o = 1'b0;
      cs_b_o = 1'b1;
      mosi_o = 1'b0;
   end
   // nb clocks, last 16 bits of w sent msb first, bits 7:3 zeroed on sample request writes; ok low means reply is unusable
   task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r, output logic ok);
      int i;
      logic [15:0] wd;
      wd = w;
      r = 16'h0000;
      if (w[15] && w[14:8] == lds_pkg::ADDR_SAMPLE_REQ) begin
         wd[7:3] = 5'h00;
      end
      cs_b_o = 1'b0;
      #200;
      for (i = nb - 1; i >= 0; i--) begin
         mosi_o = wd[i % 16];
         #6 sck_o = 1'b1;
         #6 sck_o = 1'b0;
         r = {r[14:0], miso_i};
      end
      #3 mosi_o = ~mosi_o;
      #10 cs_b_o = 1'b1;
      #300;
      ok = ~r[8 + lds_pkg::ST_LINK_ERR];
   endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Purpose: self-checking bench for the diagnostic status block
// Assumes: host model drives the link, the bench drives the analog status pins
// Notes: long counts shortened through parameters
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0, rst_b = 1'b0, sck, cs_b, mosi, miso, miso_oe, en = 1'b1, sup = 1'b1, ot = 1'b0, gok = 1'b1;
   logic [2:0] pwm = 3'h0, rch = 3'h0, hr = 3'h0, bsu = 3'h0, swt = 3'h7, tog = 3'h5, drv, rech, comp;
   logic gde, vup, ok;
   logic [7:0] st;
   logic [15:0] rd;
   int fails = 0, samples_checked = 0, n;
   initial begin
      forever #25 clk = ~clk;
   end
   lds_host_model u_lds_host_model (.sck_o(sck), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso));
   lds_top #(.GS_STARTUP_CYC(40), .GS_OPER_CYC(10), .MEAS_CYC(4), .RECH_CYC(6)) u_lds_top (
      .clk_i(clk), .rst_b_i(rst_b), .spi_sck_i(sck), .spi_cs_b_i(cs_b), .spi_mosi_i(mosi), .spi_miso_o(miso),
      .spi_miso_oe_o(miso_oe), .en_i(en), .supply_ok_i(sup), .overtemp_i(ot), .gsup_reg_ok_i(gok), .pwm_i(pwm),
      .reached_i(rch), .headroom_i(hr), .bs_uv_i(bsu), .sw_toggling_i(swt), .pwm_toggle_i(tog),
      .gate_drv_en_o(gde), .vled_update_o(vup), .chan_drive_o(drv), .recharge_o(rech), .comp_en_o(comp),
      .op_status_o(st));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // the device drives miso at every falling sck of a frame
   always @(negedge sck) begin
      if (!cs_b) begin
         chk(miso_oe, 1'b1);
      end
   end
   task automatic report_and_stop();
      $display("mismatches %0d checks %0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge clk);
      #2;
   endtask
   task automatic fr(input logic [15:0] w, input int nb);
      u_lds_host_model.xfer(w, nb, rd, ok);
      step(1);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      fr({1'b1, a, d}, 16);
   endtask
   // the reply to a read comes back in the following frame
   task automatic rdreg(input logic [6:0] a, input logic [7:0] exp);
      fr({1'b0, a, 8'h00}, 16);
      fr({1'b0, lds_pkg::ADDR_OP_STATUS, 8'h00}, 16);
      chk(rd[7:0], exp);
   endtask
   task automatic pulse_reached();
      pwm = 3'h3;
      rch = 3'h1;
      step(5);
      rch = 3'h0;
   endtask
   initial begin
      step(2);
      rst_b = 1'b1;
      step(8);
      chk(st[7], 1'b1);
      chk({gde, vup, st[3]}, 3'h7);
      chk(miso_oe, 1'b0);
      pwm = 3'h2;
      step(5);
      chk(drv, 3'h2);
      chk(comp, 3'h5);
      bsu = 3'h1;
      step(5);
      chk(comp, 3'h4);
      bsu = 3'h0;
      swt = 3'h6;
      n = 0;
      repeat (30) begin
         step(1);
         n += rech[0] + rech[2];
      end
      chk(n >= 3 && n <= 5, 1'b1);
      pulse_reached();
      rdreg(lds_pkg::ADDR_REACHED_LIVE, 8'h08);
      pwm = 3'h2;
      step(5);
      chk(st[2:0], 3'h1);
      wr(lds_pkg::ADDR_SAMPLE_REQ, 8'h01);
      chk(st[2:0], 3'h0);
      pulse_reached();
      wr(lds_pkg::ADDR_SAMPLE_REQ, 8'h01);
      chk(st[2:0], 3'h1);
      rdreg(lds_pkg::ADDR_REACHED_LIVE, 8'h00);
      rdreg(lds_pkg::ADDR_SAMPLE_REQ, 8'h00);
      hr = 3'h1;
      step(5);
      chk(st[2:0], 3'h0);
      hr = 3'h0;
      sup = 1'b0;
      step(5);
      chk({st[7], st[3], st[2:0], gde, drv}, 9'h000);
      sup = 1'b1;
      step(8);
      // reserved read, then the next reply carries the toggle bits
      fr(16'h1000, 16);
      chk(st[6], 1'b1);
      fr(16'h3700, 16);
      chk({ok, rd[7:0]}, {1'b0, 5'h00, tog});
      wr(lds_pkg::ADDR_OP_STATUS, 8'h00);
      chk(st[6], 1'b0);
      fr(16'hB700, 15);
      chk(st[6], 1'b1);
      wr(lds_pkg::ADDR_OP_STATUS, 8'h00);
      fr(16'h8000, 17);
      chk({st[6], drv}, 4'hB);
      wr(lds_pkg::ADDR_OP_STATUS, 8'h00);
      wr(lds_pkg::ADDR_REACHED_LIVE, 8'hFF);
      chk(st[6], 1'b1);
      wr(lds_pkg::ADDR_OP_STATUS, 8'h00);
      chk(st[6], 1'b0);
      ot = 1'b1;
      step(6);
      chk({st[5:3], gde}, 4'hC);
      ot = 1'b0;
      step(5);
      chk(st[5], 1'b1);
      wr(lds_pkg::ADDR_FUNC_CTRL, 8'h4E);
      chk(st[5:4], 2'h0);
      rdreg(lds_pkg::ADDR_FUNC_CTRL, 8'h8E);
      wr(lds_pkg::ADDR_FUNC_CTRL, 8'h04);
      chk(drv, 3'h2);
      wr(lds_pkg::ADDR_FUNC_CTRL, 8'h0E);
      gok = 1'b0;
      n = 0;
      while (st[4] !== 1'b1 && n < 100) begin
         step(1);
         n++;
      end
      if (n == 100) begin
         fails++;
      end
      chk(n >= 10 && n <= 50, 1'b1);
      chk({gde, vup, st[3]}, 3'h0);
      gok = 1'b1;
      en = 1'b0;
      step(5);
      chk(st[4], 1'b0);
      en = 1'b1;
      step(5);
      report_and_stop();
   end
endmodule
`default_nettype wire
